// >>> hdl/wdr_pkg.sv
// Constants, offsets and reset values for the watchdog and reset cause block
package wdr_pkg;
  localparam int unsigned WDR_ADDR_W = 8;
  localparam logic [7:0] WDR_CAUSE_OFS = 8'h00;
  localparam logic [7:0] WDR_CTRL_OFS = 8'h04;
  localparam logic [7:0] WDR_RESTART_OFS = 8'h08;
  localparam logic [7:0] WDR_COUNT_OFS = 8'h0c;
  localparam int unsigned WDR_SCAN_BIT = 4;
  localparam int unsigned WDR_TIMEOUT_BIT = 3;
  localparam int unsigned WDR_BROWN_BIT = 2;
  localparam int unsigned WDR_PIN_BIT = 1;
  localparam int unsigned WDR_POR_BIT = 0;
  localparam int unsigned WDR_PERMIT_BIT = 4;
  localparam int unsigned WDR_ENABLE_BIT = 3;
  localparam int unsigned WDR_SEL_LSB = 0;
  localparam int unsigned WDR_SEL_W = 3;
  localparam int unsigned WDR_FLAG_W = 5;
  localparam logic [4:0] WDR_CAUSE_RST = 5'h01;
  localparam logic [2:0] WDR_SEL_RST = 3'h0;
  localparam int unsigned WDR_PERMIT_CYCLES = 4;
  localparam logic [1:0] WDR_PERMIT_LAST = 2'(WDR_PERMIT_CYCLES - 1);
  localparam int unsigned WDR_BASE_PERIOD = 16384;
  localparam int unsigned WDR_CNT_W = 22;
  localparam int unsigned WDR_OSC_HZ = 1000000;
  localparam int unsigned WDR_CLK_HZ = 20000000;
  localparam logic [1:0] WDR_RESP_OKAY = 2'h0;
  localparam logic [1:0] WDR_RESP_SLVERR = 2'h2;
endpackage

// >>> hdl/wdr_tick_counter.sv
// Watchdog period counter driven by the synchronised watchdog oscillator
module wdr_tick_counter
  import wdr_pkg::*;
#(
  parameter int unsigned BASE_PERIOD = WDR_BASE_PERIOD,
  parameter int unsigned CNT_W = WDR_CNT_W
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic osc_pin,
  input wire logic enable,
  input wire logic clear,
  input wire logic [2:0] sel,
  output logic expire_ff,
  output logic [CNT_W-1:0] count_ff
);
  logic osc_s1_ff;
  logic osc_s2_ff;
  logic osc_s3_ff;
  logic tick;
  logic [CNT_W-1:0] limit;
  logic at_end;

  // Oscillator is asynchronous; only s2 and s3 feed logic
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end
    else
    begin
      osc_s1_ff <= osc_pin;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end

  assign tick = osc_s2_ff & ~osc_s3_ff;
  assign limit = CNT_W'(BASE_PERIOD) << sel;
  // At or past the end, so a shorter period picked mid-count still expires
  assign at_end = (count_ff >= limit - CNT_W'(1));

  always_ff @(posedge clk)
  begin
    if (!rst_b || clear || !enable)
      count_ff <= '0;
    else if (tick)
      count_ff <= at_end ? '0 : count_ff + CNT_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      expire_ff <= 1'b0;
    else
      expire_ff <= enable && !clear && tick && at_end;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  disabled_idle_a: assert property (!enable |=> count_ff == '0 && !expire_ff)
    else $error("counter moved while disabled");
  clear_zero_a: assert property (clear |=> count_ff == '0)
    else $error("restart did not clear counter");
  expire_end_a: assert property (expire_ff |-> $past(at_end) && $past(tick))
    else $error("expiry away from selected period");
endmodule

// >>> hdl/wdr_watchdog_reset_status.sv
// Watchdog with timed turn-off and reset cause flags behind an AXI4-Lite slave
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
module wdr_watchdog_reset_status
  import wdr_pkg::*;
#(
  parameter int unsigned BASE_PERIOD = WDR_BASE_PERIOD
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WDR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [WDR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wd_osc,
  input wire logic timeout_restart_instruction,
  input wire logic scan_reset_req,
  input wire logic brownout_req,
  input wire logic pin_reset_req,
  output logic wd_reset_req
);
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic aw_full_ff;
  logic w_full_ff;
  logic [WDR_ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;
  logic nxt_aw_full;
  logic nxt_w_full;
  logic nxt_bvalid;
  logic nxt_rvalid;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic wr_cause;
  logic wr_ctrl;
  logic wr_restart;
  logic wr_mapped;
  logic [2:0] src_s1_ff;
  logic [2:0] src_s2_ff;
  logic [2:0] src_raw;
  logic [WDR_FLAG_W-1:0] cause_ff;
  logic [WDR_FLAG_W-1:0] set_vec;
  logic permit_ff;
  logic [1:0] permit_cnt_ff;
  logic enable_ff;
  logic [2:0] sel_ff;
  logic wd_req_ff;
  logic chip_rst;
  logic restart;
  logic expire;
  logic [WDR_CNT_W-1:0] count;
  logic [WDR_ADDR_W-1:0] rd_addr;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign wd_reset_req = wd_req_ff;

  // Reset sources arrive asynchronously: two flops each before use
  assign src_raw = {scan_reset_req, brownout_req, pin_reset_req};
  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    always_ff @(posedge clk)
    begin
      if (!rst_b)
      begin
        src_s1_ff[i] <= 1'b0;
        src_s2_ff[i] <= 1'b0;
      end
      else
      begin
        src_s1_ff[i] <= src_raw[i];
        src_s2_ff[i] <= src_s1_ff[i];
      end
    end
  end

  // Write channel: address and data accepted in either order
  assign aw_take = s_axi_awvalid & awready_ff;
  assign w_take = s_axi_wvalid & wready_ff;
  assign ar_take = s_axi_arvalid & arready_ff;
  assign do_write = aw_full_ff & w_full_ff & ~bvalid_ff;

  always_comb
  begin
    nxt_aw_full = aw_full_ff;
    nxt_w_full = w_full_ff;
    nxt_bvalid = bvalid_ff;
    nxt_rvalid = rvalid_ff;
    if (do_write)
    begin
      nxt_aw_full = 1'b0;
      nxt_w_full = 1'b0;
      nxt_bvalid = 1'b1;
    end
    else
    begin
      if (aw_take)
        nxt_aw_full = 1'b1;
      if (w_take)
        nxt_w_full = 1'b1;
      if (bvalid_ff && s_axi_bready)
        nxt_bvalid = 1'b0;
    end
    if (ar_take)
      nxt_rvalid = 1'b1;
    else if (rvalid_ff && s_axi_rready)
      nxt_rvalid = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end
    else
    begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff <= nxt_w_full;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= ~nxt_aw_full & ~nxt_bvalid;
      wready_ff <= ~nxt_w_full & ~nxt_bvalid;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb0_ff <= 1'b0;
      bresp_ff <= WDR_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        awaddr_ff <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (do_write)
        bresp_ff <= wr_mapped ? WDR_RESP_OKAY : WDR_RESP_SLVERR;
    end
  end

  assign wr_mapped = (awaddr_ff == WDR_CAUSE_OFS) || (awaddr_ff == WDR_CTRL_OFS)
    || (awaddr_ff == WDR_RESTART_OFS) || (awaddr_ff == WDR_COUNT_OFS);
  // Writable registers sit in byte lane 0; a write without that lane changes nothing
  assign wr_cause = do_write & wstrb0_ff & (awaddr_ff == WDR_CAUSE_OFS);
  assign wr_ctrl = do_write & wstrb0_ff & (awaddr_ff == WDR_CTRL_OFS);
  assign wr_restart = do_write & wstrb0_ff & (awaddr_ff == WDR_RESTART_OFS);

  // Any reset source, including our own request, is a chip reset
  assign chip_rst = (|src_s2_ff) | wd_req_ff;
  assign restart = timeout_restart_instruction | wr_restart | chip_rst;

  // Cause flags: hardware set beats a software zero in the same cycle
  assign set_vec = {src_s2_ff[2], wd_req_ff, src_s2_ff[1], src_s2_ff[0], 1'b0};
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      cause_ff <= WDR_CAUSE_RST;
    else if (wr_cause)
      cause_ff <= (cause_ff & wdata_ff[WDR_FLAG_W-1:0]) | set_vec;
    else
      cause_ff <= cause_ff | set_vec;
  end

  // Permit window: open for four clocks after any write of one to it
  always_ff @(posedge clk)
  begin
    if (!rst_b || chip_rst)
    begin
      permit_ff <= 1'b0;
      permit_cnt_ff <= '0;
    end
    else if (wr_ctrl && wdata_ff[WDR_PERMIT_BIT])
    begin
      permit_ff <= 1'b1;
      permit_cnt_ff <= '0;
    end
    else if (permit_ff)
    begin
      permit_cnt_ff <= permit_cnt_ff + 2'h1;
      if (permit_cnt_ff == WDR_PERMIT_LAST)
        permit_ff <= 1'b0;
    end
  end

  // Old permit value gates the clear, so the opening write cannot disable
  always_ff @(posedge clk)
  begin
    if (!rst_b || chip_rst)
      enable_ff <= 1'b0;
    else if (wr_ctrl)
    begin
      if (wdata_ff[WDR_ENABLE_BIT])
        enable_ff <= 1'b1;
      else if (permit_ff)
        enable_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || chip_rst)
      sel_ff <= WDR_SEL_RST;
    else if (wr_ctrl)
      sel_ff <= wdata_ff[WDR_SEL_LSB +: WDR_SEL_W];
  end

  wdr_tick_counter #(
    .BASE_PERIOD(BASE_PERIOD),
    .CNT_W(WDR_CNT_W)
  ) u_counter (
    .clk(clk),
    .rst_b(rst_b),
    .osc_pin(wd_osc),
    .enable(enable_ff),
    .clear(restart),
    .sel(sel_ff),
    .expire_ff(expire),
    .count_ff(count)
  );

  // Counter restarts on its own expiry, so this is a single-cycle pulse
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      wd_req_ff <= 1'b0;
    else
      wd_req_ff <= expire & ~wd_req_ff;
  end

  // Read channel: one cycle from address to data
  assign rd_addr = s_axi_araddr;
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = WDR_RESP_OKAY;
    if (rd_addr == WDR_CAUSE_OFS)
      nxt_rdata[WDR_FLAG_W-1:0] = cause_ff;
    else if (rd_addr == WDR_CTRL_OFS)
      nxt_rdata[7:0] = {3'h0, permit_ff, enable_ff, sel_ff};
    else if (rd_addr == WDR_COUNT_OFS)
      nxt_rdata[WDR_CNT_W-1:0] = count;
    else if (rd_addr != WDR_RESTART_OFS)
      nxt_rresp = WDR_RESP_SLVERR;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= WDR_RESP_OKAY;
    end
    else
    begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= ~nxt_rvalid;
      if (ar_take)
      begin
        rdata_ff <= nxt_rdata;
        rresp_ff <= nxt_rresp;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence permit_write_s;
    wr_ctrl && wdata_ff[WDR_PERMIT_BIT] && !chip_rst;
  endsequence
  sequence permit_open_s;
    permit_ff [*4];
  endsequence

  permit_window_a: assert property (permit_write_s |=> permit_open_s)
    else $error("permit closed early");
  permit_close_a: assert property (permit_write_s ##1 (!wr_ctrl && !chip_rst) [*4]
    |=> !permit_ff)
    else $error("permit not cleared after four clocks");
  enable_hold_a: assert property (wr_ctrl && !wdata_ff[WDR_ENABLE_BIT] && !permit_ff
    && enable_ff && !chip_rst |=> enable_ff)
    else $error("enable cleared without permit");
  enable_set_a: assert property (wr_ctrl && wdata_ff[WDR_ENABLE_BIT] && !chip_rst
    |=> enable_ff)
    else $error("enable not set by write");
  reserved_zero_a: assert property (ar_take && s_axi_araddr == WDR_CTRL_OFS
    |=> rvalid_ff && rdata_ff[7:5] == 3'h0)
    else $error("reserved control bits read nonzero");
  pulse_single_a: assert property (wd_req_ff |=> !wd_req_ff)
    else $error("timeout request longer than one cycle");
  timeout_flag_a: assert property (wd_req_ff |=> cause_ff[WDR_TIMEOUT_BIT] && !enable_ff)
    else $error("timeout did not set flag or reset control");
  poweron_flag_a: assert property ($rose(rst_b) |-> cause_ff == WDR_CAUSE_RST)
    else $error("flags wrong after power-on");
  brown_wins_a: assert property (wr_cause && !wdata_ff[WDR_BROWN_BIT] && src_s2_ff[1]
    |=> cause_ff[WDR_BROWN_BIT])
    else $error("brown-out flag lost to clear");
  pin_flag_a: assert property (src_s2_ff[0] |=> cause_ff[WDR_PIN_BIT])
    else $error("pin reset flag not set");
  scan_flag_a: assert property (src_s2_ff[2] |=> cause_ff[WDR_SCAN_BIT])
    else $error("scan reset flag not set");
  no_req_off_a: assert property (!enable_ff |=> ##1 !wd_req_ff)
    else $error("reset raised while disabled");
endmodule

// >>> test/wdr_watchdog_reset_status_tb.sv
// Self-checking bench for the watchdog and reset cause block
module wdr_watchdog_reset_status_tb
  import wdr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // Short base period keeps the longest select code within the run budget
  localparam int unsigned BP = 16;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b1;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b1;
  logic osc = 1'b0;
  logic restart = 1'b0;
  logic [2:0] src = 3'h0;
  logic wd_req;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int hits = 0;
  int pcyc = -100;
  logic [7:0] cause_m = 8'h01;
  logic [7:0] ctrl_m = 8'h00;
  logic [1:0] r;
  logic [31:0] d;

  wdr_watchdog_reset_status #(.BASE_PERIOD(BP)) dut_u (.clk(clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wd_osc(osc), .timeout_restart_instruction(restart), .scan_reset_req(src[0]),
    .brownout_req(src[1]), .pin_reset_req(src[2]), .wd_reset_req(wd_req));

  initial
  begin
    forever #25 clk = ~clk;
  end

  // Oscillator runs at one eighth of the system clock, well under clk/2
  always
  begin
    repeat (4) @(posedge clk);
    osc <= ~osc;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (wd_req === 1'b1)
      hits <= hits + 1;
    if (cyc == 60000)
    begin
      failures++;
      $display("BAD t=%0t run timed out", $time);
      final_report;
    end
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_p || w_p)
    begin
      @(posedge clk);
      if (aw_p && awready === 1'b1)
      begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1)
      begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  function automatic logic [1:0] mresp(input logic [7:0] a);
    if (a inside {WDR_CAUSE_OFS, WDR_CTRL_OFS, WDR_RESTART_OFS, WDR_COUNT_OFS})
      return WDR_RESP_OKAY;
    return WDR_RESP_SLVERR;
  endfunction

  // Model write: cause bits clear on zero, enable drops only inside the permit window
  task automatic mwr(input logic [7:0] a, input logic [7:0] v);
    logic en;
    en = v[3] | (ctrl_m[3] & ((cyc - pcyc) > int'(WDR_PERMIT_CYCLES)));
    if (a == WDR_CAUSE_OFS)
      cause_m = cause_m & v;
    if (a == WDR_CTRL_OFS)
      ctrl_m = {4'h0, en, v[2:0]};
    if (a == WDR_CTRL_OFS && v[4])
      pcyc = cyc;
    wr(a, {24'h0, v});
    chk(r, mresp(a), "write response");
  endtask

  task automatic mrd(input logic [7:0] a);
    logic [7:0] pm;
    // Permit reads back one for four clocks: reads called two to five cycles after its write
    pm = ((cyc - pcyc) >= 2 && (cyc - pcyc) <= 1 + int'(WDR_PERMIT_CYCLES)) ? 8'h10 : 8'h00;
    rd(a);
    chk(r, mresp(a), "read response");
    chk(d, (a == WDR_CAUSE_OFS) ? cause_m : (a == WDR_CTRL_OFS) ? (ctrl_m | pm) : 8'h00,
      "read data");
  endtask

  initial
  begin
    int n;
    int h0;
    logic [7:0] fl [3];
    fl = '{8'h10, 8'h04, 8'h02};
    void'($urandom(38071));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    mrd(WDR_CAUSE_OFS);
    mrd(WDR_CTRL_OFS);
    mrd(8'h10);
    mwr(8'h14, 8'hff);
    $display("test reset and map done");
    mwr(WDR_CTRL_OFS, 8'hef);
    repeat (10) @(posedge clk);
    mrd(WDR_CTRL_OFS);
    mwr(WDR_CTRL_OFS, 8'h07);
    mrd(WDR_CTRL_OFS);
    mwr(WDR_CTRL_OFS, 8'h1f);
    mrd(WDR_CTRL_OFS);
    mwr(WDR_CTRL_OFS, 8'h07);
    mrd(WDR_CTRL_OFS);
    mwr(WDR_CTRL_OFS, 8'h1f);
    mwr(WDR_CTRL_OFS, 8'h07);
    mrd(WDR_CTRL_OFS);
    wstrb <= 4'h0;
    wr(WDR_CTRL_OFS, 32'h0f);
    wstrb <= 4'hf;
    mrd(WDR_CTRL_OFS);
    $display("test control sequence done");
    for (int s = 0; s < 8; s++)
    begin
      mwr(WDR_CTRL_OFS, {5'h01, s[2:0]});
      n = 0;
      while (wd_req !== 1'b1 && n < 20000)
      begin
        @(posedge clk);
        n++;
      end
      chk(32'(n > (BP << s) * 8 - 16 && n < (BP << s) * 8 + 16), 1, "period");
      @(posedge clk);
      chk(wd_req, 1'b0, "pulse width");
      ctrl_m = 8'h00;
      cause_m = cause_m | 8'h08;
      repeat (10) @(posedge clk);
      mrd(WDR_CAUSE_OFS);
      mrd(WDR_CTRL_OFS);
      rd(WDR_COUNT_OFS);
      chk(d, 32'h0, "count after reset");
      mwr(WDR_CAUSE_OFS, 8'hf7);
    end
    $display("test timeouts done");
    mwr(WDR_CTRL_OFS, 8'h08);
    h0 = hits;
    repeat (6)
    begin
      repeat ($urandom_range(20, 90)) @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
    end
    rd(WDR_COUNT_OFS);
    chk(32'(d < 3), 1, "count after restart");
    chk(hits, h0, "restart held off reset");
    mwr(WDR_CTRL_OFS, 8'h18);
    mwr(WDR_CTRL_OFS, 8'h00);
    repeat (300) @(posedge clk);
    chk(hits, h0, "disabled no reset");
    rd(WDR_COUNT_OFS);
    chk(d, 32'h0, "disabled count");
    $display("test restart and disable done");
    for (int i = 0; i < 3; i++)
    begin
      mwr(WDR_CTRL_OFS, 8'h0b);
      src[i] <= 1'b1;
      repeat (2) @(posedge clk);
      mwr(WDR_CAUSE_OFS, 8'h01);
      repeat (3) @(posedge clk);
      src[i] <= 1'b0;
      repeat (12) @(posedge clk);
      cause_m = cause_m | fl[i];
      ctrl_m = 8'h00;
      mrd(WDR_CAUSE_OFS);
      mrd(WDR_CTRL_OFS);
    end
    mwr(WDR_CAUSE_OFS, 8'h16);
    mrd(WDR_CAUSE_OFS);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    cause_m = 8'h01;
    mrd(WDR_CAUSE_OFS);
    $display("test cause flags done");
    final_report;
  end
endmodule
